// [status_flags_pkg.sv]
// Package: register map, flag positions, reset values and bus types for the status-flag block
package status_flags_pkg;

  // Register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_one_offset = 8'h04;
  localparam logic [7:0] data_high_offset = 8'h08;
  localparam logic [7:0] data_low_offset = 8'h0c;
  localparam logic [7:0] tx_data_offset = 8'h10;

  // Status flag positions
  localparam int tx_buffer_empty_flag_pos = 7;
  localparam int tc_pos = 6;
  localparam int rx_buffer_full_flag_pos = 5;
  localparam int idle_pos = 4;
  localparam int or_pos = 3;
  localparam int nf_pos = 2;
  localparam int fe_pos = 1;
  localparam int pf_pos = 0;

  // Control field positions
  localparam int frame9_pos = 0;
  localparam int parity_en_pos = 1;
  localparam int parity_odd_pos = 2;
  localparam int standby_pos = 3;

  // Reset values
  localparam logic [7:0] status_reset = 8'hc0;
  localparam logic [3:0] ctrl_reset = 4'h0;

  // Idle detection: consecutive ones per frame length
  localparam logic [3:0] idle_ones_8bit = 4'ha;
  localparam logic [3:0] idle_ones_9bit = 4'hb;

  // A frame handed over by the receive shifter
  typedef struct packed {
    logic [8:0] data;
    logic noise;
    logic stop_bit;
    logic parity_bit;
  } rx_frame_t;

  // Transmit-side events from the shifter
  typedef struct packed {
    logic load;
    logic busy;
    logic queue;
  } tx_events_t;

endpackage

// [rx_data_hold.sv]
// Receive data holding register, updated only when a frame is accepted
`timescale 1ns/1ps
module rx_data_hold (
  input wire logic clk, // System clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic write_en, // Accept a new frame
  input wire logic [8:0] write_data, // Frame data bits
  output logic [8:0] read_data // Held frame, registered
);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      read_data <= 9'h000;
    end else if (write_en) begin
      read_data <= write_data;
    end
  end

endmodule

// [status_flags.sv]
// Top: first status register flag logic with its APB register slave
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module status_flags (
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset, // Asynchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rx_pin, // Receive line from the remote node
  input wire logic rx_bit_tick, // One-cycle pulse per received bit time
  input wire logic rx_frame_done, // Pulse: a frame's stop bit completed
  input wire status_flags_pkg::rx_frame_t rx_frame, // Frame contents at rx_frame_done
  input wire status_flags_pkg::tx_events_t tx_events, // Transmit shifter events
  input wire logic wake_event, // Pulse: wakeup detected, clears standby
  output logic tx_data_valid, // Transmit data register holds unsent data
  output logic [8:0] tx_data, // Transmit data register contents
  output logic tx_line_idle, // Drive transmit line high
  output logic rx_request // Receiver request, gated by standby
);

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] armed_reg;
  logic [3:0] ctrl_reg;
  logic [3:0] ones_count_reg;
  logic idle_allowed_reg;
  logic [2:0] rx_sync_reg;
  logic rx_level_reg;
  logic [8:0] held_data;
  logic tx_valid_reg;
  logic [8:0] tx_data_reg;

  logic setup_phase;
  logic wr_access;
  logic rd_access;
  logic status_rd;
  logic data_low_rd;
  logic data_low_wr;
  logic frame_accepted;
  logic overrun_event;
  logic parity_calc;
  logic idle_event;
  logic [3:0] idle_target;
  logic [31:0] read_mux;
  logic hit;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return addr_is(a, status_flags_pkg::ctrl_offset) ||
      addr_is(a, status_flags_pkg::status_one_offset) ||
      addr_is(a, status_flags_pkg::data_high_offset) ||
      addr_is(a, status_flags_pkg::data_low_offset) ||
      addr_is(a, status_flags_pkg::tx_data_offset);
  endfunction

  // Zero-wait slave: pready is raised in the first access cycle
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite;
  assign rd_access = psel && penable && pready && !pwrite;
  assign hit = mapped(paddr);
  assign status_rd = rd_access && addr_is(paddr, status_flags_pkg::status_one_offset);
  assign data_low_rd = rd_access && addr_is(paddr, status_flags_pkg::data_low_offset);
  assign data_low_wr = wr_access && addr_is(paddr, status_flags_pkg::data_low_offset);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    if (addr_is(paddr, status_flags_pkg::ctrl_offset)) begin
      read_mux[3:0] = ctrl_reg;
    end else if (addr_is(paddr, status_flags_pkg::status_one_offset)) begin
      read_mux[7:0] = status_reg;
    end else if (addr_is(paddr, status_flags_pkg::data_high_offset)) begin
      read_mux[7] = held_data[8];
    end else if (addr_is(paddr, status_flags_pkg::data_low_offset)) begin
      read_mux[7:0] = held_data[7:0];
    end else if (addr_is(paddr, status_flags_pkg::tx_data_offset)) begin
      read_mux[8:0] = tx_data_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : read_mux;
      pslverr <= !hit;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Control register; standby bit is cleared by hardware on wake
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= status_flags_pkg::ctrl_reset;
    end else begin
      if (wr_access && addr_is(paddr, status_flags_pkg::ctrl_offset)) begin
        ctrl_reg <= pwdata[3:0];
      end
      if (wake_event) begin
        ctrl_reg[status_flags_pkg::standby_pos] <= 1'b0;
      end
    end
  end

  // Transmit data register (9 bits); high bit written at its own offset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_data_reg <= 9'h000;
      tx_valid_reg <= 1'b0;
    end else begin
      if (wr_access && addr_is(paddr, status_flags_pkg::data_high_offset)) begin
        tx_data_reg[8] <= pwdata[6];
      end
      if (data_low_wr) begin
        tx_data_reg[7:0] <= pwdata[7:0];
        tx_valid_reg <= 1'b1;
      end else if (tx_events.load) begin
        tx_valid_reg <= 1'b0;
      end
    end
  end

  // Receive line: three flops, a change counts once the last two agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_sync_reg <= 3'b111;
      rx_level_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_level_reg <= rx_sync_reg[2];
      end
    end
  end

  // Reception blocked while framing error stands
  assign frame_accepted = rx_frame_done && !status_reg[status_flags_pkg::fe_pos] &&
    !status_reg[status_flags_pkg::rx_buffer_full_flag_pos];
  assign overrun_event = rx_frame_done && !status_reg[status_flags_pkg::fe_pos] &&
    status_reg[status_flags_pkg::rx_buffer_full_flag_pos];

  // New frame is written only when accepted, so overrun keeps old data
  rx_data_hold hold_inst (
    .clk(clk),
    .reset(reset),
    .write_en(frame_accepted),
    .write_data(rx_frame.data),
    .read_data(held_data)
  );

  // Received parity check: even type expects even total, odd type odd
  always_comb begin
    if (ctrl_reg[status_flags_pkg::frame9_pos]) begin
      parity_calc = ^rx_frame.data[7:0];
    end else begin
      parity_calc = ^rx_frame.data[6:0];
    end
    parity_calc = parity_calc ^ rx_frame.parity_bit ^ ctrl_reg[status_flags_pkg::parity_odd_pos];
  end

  // Idle counter runs on bit ticks; target depends on frame length
  assign idle_target = ctrl_reg[status_flags_pkg::frame9_pos] ?
    status_flags_pkg::idle_ones_9bit : status_flags_pkg::idle_ones_8bit;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ones_count_reg <= 4'h0;
    end else if (!rx_level_reg) begin
      ones_count_reg <= 4'h0;
    end else if (rx_bit_tick && ones_count_reg != idle_target) begin
      ones_count_reg <= ones_count_reg + 4'h1;
    end
  end

  assign idle_event = rx_level_reg && rx_bit_tick && ones_count_reg == idle_target - 4'h1 &&
    idle_allowed_reg && !ctrl_reg[status_flags_pkg::standby_pos];

  // After an idle report, a new valid frame must re-enable it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_allowed_reg <= 1'b1;
    end else if (frame_accepted) begin
      idle_allowed_reg <= 1'b1;
    end else if (idle_event) begin
      idle_allowed_reg <= 1'b0;
    end
  end

  // Arm each clear only for flags seen set by a status read. The word returned
  // was captured at the setup edge, so arm from it: a flag raised between setup
  // and access was never seen and must survive the following data access.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed_reg <= 8'h00;
    end else if (status_rd) begin
      armed_reg <= prdata[7:0];
    end else if (data_low_rd) begin
      armed_reg[5:0] <= 6'h00;
    end else if (data_low_wr) begin
      armed_reg[7:6] <= 2'b00;
    end
  end

  always_comb begin
    status_next = status_reg;
    // Software clears first so that hardware sets win, except complete flag
    if (data_low_wr) begin
      status_next[status_flags_pkg::tx_buffer_empty_flag_pos] =
        status_reg[status_flags_pkg::tx_buffer_empty_flag_pos] && !armed_reg[status_flags_pkg::tx_buffer_empty_flag_pos];
      status_next[status_flags_pkg::tc_pos] =
        status_reg[status_flags_pkg::tc_pos] && !armed_reg[status_flags_pkg::tc_pos];
    end
    if (data_low_rd) begin
      status_next[5:0] = status_reg[5:0] & ~armed_reg[5:0];
    end
    if (tx_events.load) begin
      status_next[status_flags_pkg::tx_buffer_empty_flag_pos] = 1'b1;
    end
    if (status_next[status_flags_pkg::tx_buffer_empty_flag_pos] && !tx_events.busy) begin
      status_next[status_flags_pkg::tc_pos] = 1'b1;
    end
    if (tx_events.busy || tx_events.queue || data_low_wr) begin
      status_next[status_flags_pkg::tc_pos] = 1'b0;
    end
    if (frame_accepted) begin
      status_next[status_flags_pkg::rx_buffer_full_flag_pos] = 1'b1;
      status_next[status_flags_pkg::nf_pos] = rx_frame.noise;
      status_next[status_flags_pkg::fe_pos] = !rx_frame.stop_bit;
      status_next[status_flags_pkg::pf_pos] =
        ctrl_reg[status_flags_pkg::parity_en_pos] && parity_calc;
    end
    if (overrun_event) begin
      status_next[status_flags_pkg::or_pos] = 1'b1;
    end
    if (idle_event) begin
      status_next[status_flags_pkg::idle_pos] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= status_flags_pkg::status_reset;
    end else begin
      status_reg <= status_next;
    end
  end

  // Outputs registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_data_valid <= 1'b0;
      tx_data <= 9'h000;
      tx_line_idle <= 1'b1;
      rx_request <= 1'b0;
    end else begin
      tx_data_valid <= tx_valid_reg;
      tx_data <= tx_data_reg;
      tx_line_idle <= status_next[status_flags_pkg::tc_pos];
      rx_request <= !ctrl_reg[status_flags_pkg::standby_pos] &&
        (status_next[status_flags_pkg::rx_buffer_full_flag_pos] || status_next[status_flags_pkg::or_pos] ||
        status_next[status_flags_pkg::idle_pos]);
    end
  end

endmodule

// [status_flags_sva.sv]
// Checker: port-level timing of the status-flag block
`timescale 1ns/1ps
module status_flags_sva (
  input wire logic clk, // clock
  input wire logic reset, // async reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire status_flags_pkg::tx_events_t tx_events, // shifter events
  input wire logic tx_data_valid, // unsent data
  input wire logic [8:0] tx_data, // tx data
  input wire logic tx_line_idle // line idle
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic acc;
  assign acc = psel && penable && pready;
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_err_unmapped: assert property (acc && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not flagged");
  a_ok_mapped: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 8'h10 |-> !pslverr)
    else $error("mapped access flagged");
  a_wr_txdata: assert property (
    acc && pwrite && paddr == status_flags_pkg::data_low_offset
    |=> ##1 tx_data_valid && tx_data[7:0] == $past(pwdata[7:0], 2))
    else $error("data write not held");
  a_load_empty: assert property (
    tx_events.load && !(acc && pwrite) |=> ##1 !tx_data_valid)
    else $error("load left data pending");
  a_busy_tc: assert property (tx_events.busy [*3] |-> !tx_line_idle)
    else $error("line idle while sending");
  a_queue_tc: assert property (tx_events.queue |=> ##[0:1] !tx_line_idle)
    else $error("queue did not clear complete");
  cover property (acc && pslverr);
  cover property (tx_events.queue && !tx_events.busy);
  cover property (acc && !pwrite && paddr == status_flags_pkg::data_low_offset);
endmodule
bind status_flags status_flags_sva u_sva (.clk, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .tx_events, .tx_data_valid, .tx_data, .tx_line_idle);

// [serial_node.sv]
// Remote serial node: receive line, bit strobes and frame events
`timescale 1ns/1ps
module serial_node (
  input wire logic clk, // clock
  output logic rx_pin, // line, idles high
  output logic rx_bit_tick, // bit strobe
  output logic rx_frame_done, // frame end
  output status_flags_pkg::rx_frame_t rx_frame // frame contents
);
  initial begin
    rx_pin = 1'b1;
    rx_bit_tick = 1'b0;
    rx_frame_done = 1'b0;
    rx_frame = '0;
  end
  // Pin settles well before the strobe so the input synchroniser has caught up
  task automatic bit_out(input logic b);
    rx_pin <= b;
    repeat (6) @(posedge clk);
    rx_bit_tick <= 1'b1;
    @(posedge clk);
    rx_bit_tick <= 1'b0;
  endtask
  task automatic ones(input int n);
    for (int i = 0; i < n; i++) bit_out(1'b1);
  endtask
  task automatic send(input logic [8:0] d, input logic nz, input logic sb, input logic pb);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    bit_out(sb);
    rx_frame <= {d, nz, sb, pb};
    rx_frame_done <= 1'b1;
    @(posedge clk);
    rx_frame_done <= 1'b0;
    // Contents are only valid with the strobe, so scramble them afterwards
    rx_frame <= ~rx_frame;
    rx_pin <= 1'b1;
  endtask
endmodule

// [tb.sv]
// Testbench: register-level scenarios for the status-flag block
`timescale 1ns/1ps
module tb;
  logic clk, reset, psel, penable, pwrite;
  logic wake_event, pready, pslverr, er, rx_pin, rx_bit_tick, rx_frame_done;
  logic tx_data_valid, tx_line_idle, rx_request;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d, e;
  logic [8:0] tx_data;
  status_flags_pkg::rx_frame_t rx_frame;
  status_flags_pkg::tx_events_t tx_events;
  int err_total = 0, tests_run = 0;
  localparam logic [7:0] st = status_flags_pkg::status_one_offset;
  localparam logic [7:0] dl = status_flags_pkg::data_low_offset;
  // ctrl, data, noise/stop/parity, expected status
  logic [31:0] tbl [7] = '{32'h000106e4, 32'h000102e0, 32'h020102e1, 32'h020302e0,
    32'h060102e0, 32'h060302e1, 32'h038002e1};
  always #5 clk = ~clk;
  status_flags u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_pin, .rx_bit_tick, .rx_frame_done, .rx_frame, .tx_events,
    .wake_event, .tx_data_valid, .tx_data, .tx_line_idle, .rx_request);
  serial_node u_node (.clk, .rx_pin, .rx_bit_tick, .rx_frame_done, .rx_frame);
  task automatic end_sim();
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 16) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), x, d);
    chk($sformatf("pslverr %h", a), {31'h0, a > 8'h10}, {31'h0, er});
  endtask
  task automatic tx_ev(input logic [2:0] v);
    tx_events <= v;
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wake_event = 1'b0;
    tx_events = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(st, 32'hc0);
    rd(8'h40, 32'h0);
    apb(1'b1, st, 32'h0);
    rd(st, 32'hc0);
    apb(1'b1, dl, 32'h33);
    rd(st, 32'h00);
    rd(8'h10, 32'h33);
    tx_ev(3'b110);
    tx_ev(3'b010);
    rd(st, 32'h80);
    tx_ev(3'b000);
    rd(st, 32'hc0);
    chk("tx_line_idle", 32'h1, {31'h0, tx_line_idle});
    tx_ev(3'b001);
    tx_ev(3'b010);
    rd(st, 32'h80);
    tx_ev(3'b000);
    rd(st, 32'hc0);
    u_node.send(9'h05a, 1'b0, 1'b1, 1'b0);
    rd(dl, 32'h5a);
    rd(st, 32'he0);
    chk("rx_request", 32'h1, {31'h0, rx_request});
    rd(dl, 32'h5a);
    rd(st, 32'hc0);
    u_node.send(9'h011, 1'b0, 1'b1, 1'b0);
    rd(st, 32'he0);
    u_node.send(9'h022, 1'b1, 1'b0, 1'b0);
    rd(dl, 32'h11);
    rd(st, 32'hc8);
    rd(dl, 32'h11);
    rd(st, 32'hc0);
    for (int i = 0; i < 7; i++) begin
      e = tbl[i];
      apb(1'b1, 8'h00, {24'h0, e[31:24]});
      u_node.send({1'b0, e[23:16]}, e[10], e[9], e[8]);
      rd(st, {24'h0, e[7:0]});
      rd(dl, {24'h0, e[23:16]});
    end
    apb(1'b1, 8'h00, 32'h0);
    u_node.send(9'h044, 1'b0, 1'b0, 1'b0);
    u_node.send(9'h055, 1'b0, 1'b1, 1'b0);
    rd(st, 32'he2);
    rd(dl, 32'h44);
    rd(st, 32'hc0);
    u_node.send(9'h066, 1'b0, 1'b1, 1'b0);
    rd(st, 32'he0);
    rd(dl, 32'h66);
    u_node.bit_out(1'b0);
    u_node.ones(9);
    rd(st, 32'hc0);
    u_node.ones(1);
    rd(st, 32'hd0);
    rd(dl, 32'h66);
    rd(st, 32'hc0);
    u_node.bit_out(1'b0);
    u_node.ones(10);
    rd(st, 32'hc0);
    u_node.send(9'h077, 1'b0, 1'b1, 1'b0);
    rd(st, 32'he0);
    rd(dl, 32'h77);
    apb(1'b1, 8'h00, 32'h8);
    u_node.bit_out(1'b0);
    u_node.ones(10);
    rd(st, 32'hc0);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    rd(8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    u_node.send(9'h188, 1'b0, 1'b1, 1'b0);
    rd(st, 32'he0);
    rd(8'h08, 32'h80);
    rd(dl, 32'h88);
    u_node.bit_out(1'b0);
    u_node.ones(10);
    rd(st, 32'hc0);
    u_node.ones(1);
    rd(st, 32'hd0);
    end_sim();
  end
endmodule
